// ==== src/swpc_port_regs.sv ====
// Purpose: Identifier, command and primary status of a switch upstream port
// Assumes: Configuration requests and events arrive on CLK_SYS_I
// Notes:   One request at a time; answer one cycle after it is taken
`timescale 1ns/1ps
`default_nettype none
`include "swpc_regs.svh"
module swpc_port_regs #(
    // Arbitrary value, replaced by the management load
    parameter logic [15:0] ID_DEFAULT = 16'h5a5a
) (
    // Clock and reset
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  ARST_N_I,
    // Configuration requests
    input  wire logic                  CFG_REQ_I,
    input  wire logic                  CFG_WR_I,
    input  wire logic [11:0]           CFG_ADDR_I,
    input  wire logic [3:0]            CFG_BE_I,
    input  wire swpc_pkg::swpc_word_t  CFG_WDATA_I,
    output logic                       CFG_ACK_O,
    output swpc_pkg::swpc_word_t       CFG_RDATA_O,
    // Identifier load from management port or EEPROM
    input  wire logic                  ID_LOAD_I,
    input  wire swpc_pkg::swpc_half_t  ID_LOAD_VAL_I,
    // Primary decode
    input  wire logic                  PRI_IO_REQ_I,
    input  wire logic                  PRI_MEM_REQ_I,
    output logic                       PRI_IO_ACC_O,
    output logic                       PRI_MEM_ACC_O,
    // Upstream forwarding
    input  wire logic                  US_REQ_I,
    input  wire logic                  US_NP_I,
    input  wire logic                  OWN_REQ_I,
    output logic                       US_FWD_O,
    output logic                       US_UR_O,
    output logic                       US_UR_CPL_O,
    output logic                       OWN_REQ_GO_O,
    // Errors
    input  wire logic                  PAR_ERR_I,
    input  wire logic                  ERR_DET_I,
    input  wire logic                  ERR_MSG_SENT_I,
    output logic                       PAR_ACT_O,
    output logic                       ERR_MSG_REQ_O,
    // Completion events
    input  wire logic                  CA_SENT_I,
    input  wire logic                  CA_RCVD_I,
    input  wire logic                  UR_RCVD_I,
    input  wire logic                  POISON_I,
    // Interrupt messages
    input  wire logic                  OWN_INTX_I,
    input  wire logic                  DS_INTX_I,
    output logic                       OWN_INTX_O,
    output logic                       DS_INTX_O
);
    import swpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    swpc_acc_e  state_r;
    swpc_acc_e  state_nxt;
    swpc_half_t id_r;
    swpc_half_t cmd_r;
    swpc_half_t cmd_nxt;
    swpc_word_t rdata_r;
    logic [7:0] flags;
    logic [7:0] w1c;
    logic       take;
    logic       hit_id;
    logic       hit_cs;
    logic       wr_cs;

    swpc_ctl_if ctl ();

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Read value of a dword, zero where nothing is mapped
    function automatic swpc_word_t rd_word(
        input logic [11:0] addr,
        input swpc_half_t  id,
        input swpc_half_t  cmd,
        input logic [7:0]  flg
    );
        swpc_word_t v;
        v = 32'h0000_0000;
        if ({addr[11:2], 2'b00} == `SWPC_OFF_ID) begin
            v = {id, 16'h0000};
        end else if ({addr[11:2], 2'b00} == `SWPC_OFF_CMDSTS) begin
            v = {flg, `SWPC_STS_LO_CONST,
                 cmd & `SWPC_CMD_WR_MASK};
        end
        return v;
    endfunction : rd_word

    // Command bits a write may touch, per byte lane
    function automatic swpc_half_t cmd_lanes(input logic [1:0] be);
        swpc_half_t m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return m & `SWPC_CMD_WR_MASK;
    endfunction : cmd_lanes

    ////////////////////////////////////////////////////////////////////////
    // Request decode
    assign take   = CFG_REQ_I && (state_r == SWPC_IDLE);
    assign hit_id = ({CFG_ADDR_I[11:2], 2'b00} == `SWPC_OFF_ID);
    assign hit_cs = ({CFG_ADDR_I[11:2], 2'b00} == `SWPC_OFF_CMDSTS);
    assign wr_cs  = take && CFG_WR_I && hit_cs;

    // Access sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SWPC_IDLE: begin
                if (CFG_REQ_I) begin
                    state_nxt = SWPC_RESP;
                end
            end
            SWPC_RESP: begin
                state_nxt = SWPC_IDLE;
            end
            default: begin
                state_nxt = SWPC_IDLE;
            end
        endcase
    end

    // Access sequencer state
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r <= SWPC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Answer strobe, one cycle after the take
    assign CFG_ACK_O = (state_r == SWPC_RESP);

    ////////////////////////////////////////////////////////////////////////
    // Identifier, read-only to configuration writes
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            id_r <= ID_DEFAULT;
        end else if (ID_LOAD_I) begin
            id_r <= ID_LOAD_VAL_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command register, only implemented bits writable
    always_comb begin
        cmd_nxt = cmd_r;
        if (wr_cs) begin
            cmd_nxt = (cmd_r & ~cmd_lanes(CFG_BE_I[1:0]))
                    | (CFG_WDATA_I[15:0] & cmd_lanes(CFG_BE_I[1:0]));
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cmd_r <= `SWPC_CMD_RST;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    // Enables handed to the users
    assign ctl.io_en    = cmd_r[`SWPC_CMD_IO];
    assign ctl.mem_en   = cmd_r[`SWPC_CMD_MEM];
    assign ctl.bme      = cmd_r[`SWPC_CMD_BME];
    assign ctl.perr_en  = cmd_r[`SWPC_CMD_PERR];
    assign ctl.serr_en  = cmd_r[`SWPC_CMD_SERR];
    assign ctl.intx_dis = cmd_r[`SWPC_CMD_INTXD];

    ////////////////////////////////////////////////////////////////////////
    // Status upper byte, bits 31, 30 and 24 write-one-to-clear through lane 3
    assign w1c = (wr_cs && CFG_BE_I[3]) ? CFG_WDATA_I[31:24] : 8'h00;

    swpc_event_flags u_flags (
        .clk_i      (CLK_SYS_I),
        .arst_n_i   (ARST_N_I),
        .ctl        (ctl),
        .par_err_i  (PAR_ERR_I),
        .ca_sent_i  (CA_SENT_I),
        .ca_rcvd_i  (CA_RCVD_I),
        .ur_rcvd_i  (UR_RCVD_I),
        .err_sent_i (ERR_MSG_SENT_I),
        .poison_i   (POISON_I),
        .w1c_i      (w1c),
        .flags_o    (flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured at the take; writes answer zero
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_r <= 32'h0000_0000;
        end else if (take) begin
            rdata_r <= CFG_WR_I ? 32'h0000_0000
                     : rd_word(CFG_ADDR_I, id_r, cmd_r, flags);
        end
    end
    assign CFG_RDATA_O = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Traffic gating by the command enables
    swpc_traffic_gate u_gate (
        .clk_i       (CLK_SYS_I),
        .arst_n_i    (ARST_N_I),
        .ctl         (ctl),
        .io_req_i    (PRI_IO_REQ_I),
        .mem_req_i   (PRI_MEM_REQ_I),
        .us_req_i    (US_REQ_I),
        .us_np_i     (US_NP_I),
        .own_req_i   (OWN_REQ_I),
        .par_err_i   (PAR_ERR_I),
        .err_det_i   (ERR_DET_I),
        .own_intx_i  (OWN_INTX_I),
        .ds_intx_i   (DS_INTX_I),
        .io_acc_o    (PRI_IO_ACC_O),
        .mem_acc_o   (PRI_MEM_ACC_O),
        .us_fwd_o    (US_FWD_O),
        .us_ur_o     (US_UR_O),
        .us_ur_cpl_o (US_UR_CPL_O),
        .own_go_o    (OWN_REQ_GO_O),
        .par_act_o   (PAR_ACT_O),
        .err_req_o   (ERR_MSG_REQ_O),
        .own_intx_o  (OWN_INTX_O),
        .ds_intx_o   (DS_INTX_O)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);

    // Configuration writes never move the identifier
    property p_id_ro;
        take && CFG_WR_I && hit_id && !ID_LOAD_I |=> $stable(id_r);
    endproperty
    a_id_ro: assert property (p_id_ro)
        else $error("identifier changed by a configuration write");

    // Loaded identifier appears on the next read of dword 0
    property p_id_load;
        ID_LOAD_I ##1 (take && !CFG_WR_I && hit_id && !ID_LOAD_I)
        |=> CFG_RDATA_O[31:16] == $past(ID_LOAD_VAL_I, 2);
    endproperty
    a_id_load: assert property (p_id_load)
        else $error("loaded identifier not read back");

    // I/O answered only while enabled
    property p_io_gate;
        PRI_IO_REQ_I |=> PRI_IO_ACC_O == $past(cmd_r[`SWPC_CMD_IO]);
    endproperty
    a_io_gate: assert property (p_io_gate)
        else $error("I/O decode not following enable");

    // Memory answered only while enabled
    property p_mem_gate;
        PRI_MEM_REQ_I |=> PRI_MEM_ACC_O == $past(cmd_r[`SWPC_CMD_MEM]);
    endproperty
    a_mem_gate: assert property (p_mem_gate)
        else $error("memory decode not following enable");

    // No bus mastering: non-posted gets UR completion, nothing forwarded
    property p_bme_off;
        US_REQ_I && US_NP_I && !cmd_r[`SWPC_CMD_BME]
        |=> US_UR_CPL_O && US_UR_O && !US_FWD_O;
    endproperty
    a_bme_off: assert property (p_bme_off)
        else $error("request not refused with UR");

    // Own requests held back without bus mastering
    property p_own_hold;
        !cmd_r[`SWPC_CMD_BME] |=> !OWN_REQ_GO_O;
    endproperty
    a_own_hold: assert property (p_own_hold)
        else $error("own request issued while mastering off");

    // Bus mastering on: forwarded, never refused
    property p_bme_on;
        US_REQ_I && cmd_r[`SWPC_CMD_BME] |=> US_FWD_O && !US_UR_O;
    endproperty
    a_bme_on: assert property (p_bme_on)
        else $error("request not forwarded upstream");

    // Legacy and reserved bits read as zero
    property p_const_zero;
        take && !CFG_WR_I && hit_cs
        |=> CFG_ACK_O && (CFG_RDATA_O & (`SWPC_LEGACY_MASK
            | `SWPC_RSVD_MASK)) == 32'h0000_0000;
    endproperty
    a_const_zero: assert property (p_const_zero)
        else $error("legacy or reserved bit reads nonzero");

    // Reserved command bits never hold a one
    property p_rsvd_cmd;
        wr_cs ##1 1'b1 |-> (cmd_r & ~`SWPC_CMD_WR_MASK) == 16'h0000;
    endproperty
    a_rsvd_cmd: assert property (p_rsvd_cmd)
        else $error("reserved command bit stored");

    // Parity action only with parity response on
    property p_par_act;
        PAR_ERR_I |=> PAR_ACT_O == $past(cmd_r[`SWPC_CMD_PERR]);
    endproperty
    a_par_act: assert property (p_par_act)
        else $error("parity action not following enable");

    // Error messages only with reporting on
    property p_err_rep;
        ERR_DET_I |=> ERR_MSG_REQ_O == $past(cmd_r[`SWPC_CMD_SERR]);
    endproperty
    a_err_rep: assert property (p_err_rep)
        else $error("error report not following enable");

    // Own INTx blocked, downstream INTx always passed
    property p_intx;
        (OWN_INTX_I && cmd_r[`SWPC_CMD_INTXD] |=> !OWN_INTX_O)
        and (DS_INTX_I |=> DS_INTX_O);
    endproperty
    a_intx: assert property (p_intx)
        else $error("INTx gating wrong");

    // Pending bit zero, capability bit one
    property p_sts_const;
        take && !CFG_WR_I && hit_cs
        |=> !CFG_RDATA_O[19] && CFG_RDATA_O[20];
    endproperty
    a_sts_const: assert property (p_sts_const)
        else $error("status constant bits wrong");

    // Abort and UR flags record every event and stay set until reset
    property p_abort_sticky;
        CA_SENT_I || CA_RCVD_I || UR_RCVD_I
        |=> (flags[5:3] & {$past(UR_RCVD_I), $past(CA_RCVD_I),
             $past(CA_SENT_I)}) == {$past(UR_RCVD_I), $past(CA_RCVD_I),
             $past(CA_SENT_I)}
             ##1 (flags[5:3] & $past(flags[5:3])) == $past(flags[5:3]);
    endproperty
    a_abort_sticky: assert property (p_abort_sticky)
        else $error("completion status flag not recorded");

    // Answer is exactly one cycle wide
    property p_ack;
        take |=> CFG_ACK_O ##1 !CFG_ACK_O;
    endproperty
    a_ack: assert property (p_ack)
        else $error("answer strobe timing wrong");

    // Main scenarios
    c_read_cs:  cover property (take && !CFG_WR_I && hit_cs);
    c_write_cs: cover property (wr_cs && CFG_BE_I[0]);
    c_w1c:      cover property (wr_cs && flags[7] && CFG_WDATA_I[31]);
    c_set_clr:  cover property (POISON_I && wr_cs && CFG_WDATA_I[31]);
endmodule : swpc_port_regs
`default_nettype wire

// ==== src/swpc_regs.svh ====
// Purpose: Offsets, field positions and reset values of the port registers
// Assumes: Byte addresses of configuration space, dword aligned
// Notes:   Definitions only
//
// Notes on behaviour
// - Read-only 16-bit identifier in bits 31:16 of dword 0, loadable.
// - Command bit 0 enables answering primary I/O; clear ignores; resets 0.
// - Command bit 1 enables answering primary memory; resets 0.
// - Bit 2 clear: no own upstream requests; downstream ones get UR.
// - Bit 2 set: memory and I/O requests forwarded upstream; resets 0.
// - Legacy command bits 3,4,5,7,9, status 21,23,26:25 read zero.
// - Command bit 6 set: parity errors get their normal action.
// - Command bit 8 enables fatal/non-fatal error reporting; resets 0.
// - Command bit 10 blocks own INTx, not forwarded INTx; resets 0.
// - Status bit 19 always reads zero.
// - Status bit 20 reads one; capability pointer at 34h, which this bank does not map, so it reads zero.
// - Status 24 sets on parity error only with bit 6; write-one clears.
// - Status 27 sets when port completes with Completer Abort.
// - Status 28 sets on received Completer Abort completion.
// - Status 29 sets on received Unsupported Request completion.
// - Status 30 sets on error message sent with bit 8; write-one clears.
// - Status 31 sets on received poisoned TLP; write-one clears.
`ifndef SWPC_REGS_SVH
`define SWPC_REGS_SVH
`define SWPC_OFF_ID       12'h000
`define SWPC_OFF_CMDSTS   12'h004
`define SWPC_CAP_PTR_OFF  8'h34
`define SWPC_CMD_IO       0
`define SWPC_CMD_MEM      1
`define SWPC_CMD_BME      2
`define SWPC_CMD_PERR     6
`define SWPC_CMD_SERR     8
`define SWPC_CMD_INTXD    10
`define SWPC_CMD_RST      16'h0000
`define SWPC_CMD_WR_MASK  16'h0547
`define SWPC_STS_LO_CONST 8'h10
`define SWPC_STS_W1C_MASK 8'hc1
`define SWPC_FLG_RST      8'h00
`define SWPC_LEGACY_MASK  32'h06a002b8
`define SWPC_RSVD_MASK    32'h0047f800
`define SWPC_ACK_CYCLES   1
`endif

// ==== src/swpc_pkg.sv ====
// Purpose: Types shared by the port register files
// Assumes: Nothing
// Notes:   Constants live in swpc_regs.svh
package swpc_pkg;
    typedef logic [31:0] swpc_word_t;
    typedef logic [15:0] swpc_half_t;
    // Access sequencer, Gray along idle -> answer
    typedef enum logic [1:0] {
        SWPC_IDLE = 2'b00,
        SWPC_RESP = 2'b01
    } swpc_acc_e;
endpackage : swpc_pkg

// ==== src/swpc_ctl_if.sv ====
// Purpose: Command enables handed from the register bank to its users
// Assumes: One clock domain
// Notes:   Levels, straight from the command register
`timescale 1ns/1ps
`default_nettype none
interface swpc_ctl_if;
    logic io_en;
    logic mem_en;
    logic bme;
    logic perr_en;
    logic serr_en;
    logic intx_dis;
    modport src (output io_en, mem_en, bme, perr_en, serr_en, intx_dis);
    modport snk (input io_en, mem_en, bme, perr_en, serr_en, intx_dis);
endinterface : swpc_ctl_if
`default_nettype wire

// ==== src/swpc_event_flags.sv ====
// Purpose: Sticky error flags of the primary status upper byte
// Assumes: Events are one-cycle pulses on the system clock
// Notes:   A set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
`include "swpc_regs.svh"
module swpc_event_flags (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Enables and events
    swpc_ctl_if.snk         ctl,
    input  wire logic       par_err_i,
    input  wire logic       ca_sent_i,
    input  wire logic       ca_rcvd_i,
    input  wire logic       ur_rcvd_i,
    input  wire logic       err_sent_i,
    input  wire logic       poison_i,
    input  wire logic [7:0] w1c_i,
    // Flags, status bits 31:24
    output logic [7:0]      flags_o
);
    import swpc_pkg::*;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] flags_r;

    // Event vector in status bit order
    assign set_v = {poison_i,
                    err_sent_i & ctl.serr_en,
                    ur_rcvd_i,
                    ca_rcvd_i,
                    ca_sent_i,
                    2'b00,
                    par_err_i & ctl.perr_en};
    assign clr_v = w1c_i & `SWPC_STS_W1C_MASK;

    // Sticky flags, set beats clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_r <= `SWPC_FLG_RST;
        end else begin
            flags_r <= (flags_r & ~clr_v) | set_v;
        end
    end
    assign flags_o = flags_r;

    ////////////////////////////////////////////////////////////////////////
    property p_par_gated;
        @(posedge clk_i) disable iff (!arst_n_i)
        !ctl.perr_en && !flags_r[0] |=> !flags_r[0];
    endproperty
    a_par_gated: assert property (p_par_gated)
        else $error("parity flag set while parity response off");
    property p_serr_flag;
        @(posedge clk_i) disable iff (!arst_n_i)
        err_sent_i && ctl.serr_en |=> flags_r[6];
    endproperty
    a_serr_flag: assert property (p_serr_flag)
        else $error("system error flag missed");
    property p_poison_flag;
        @(posedge clk_i) disable iff (!arst_n_i)
        poison_i |=> flags_r[7] ##1 (flags_r[7] || $past(w1c_i[7]));
    endproperty
    a_poison_flag: assert property (p_poison_flag)
        else $error("poisoned flag missed or dropped without clear");
endmodule : swpc_event_flags
`default_nettype wire

// ==== src/swpc_traffic_gate.sv ====
// Purpose: Applies the command enables to decode, forwarding and messages
// Assumes: Requests are one-cycle pulses on the system clock
// Notes:   Every answer is registered, one cycle after its request
`timescale 1ns/1ps
`default_nettype none
module swpc_traffic_gate (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Enables
    swpc_ctl_if.snk   ctl,
    // Requests
    input  wire logic io_req_i,
    input  wire logic mem_req_i,
    input  wire logic us_req_i,
    input  wire logic us_np_i,
    input  wire logic own_req_i,
    input  wire logic par_err_i,
    input  wire logic err_det_i,
    input  wire logic own_intx_i,
    input  wire logic ds_intx_i,
    // Answers
    output logic      io_acc_o,
    output logic      mem_acc_o,
    output logic      us_fwd_o,
    output logic      us_ur_o,
    output logic      us_ur_cpl_o,
    output logic      own_go_o,
    output logic      par_act_o,
    output logic      err_req_o,
    output logic      own_intx_o,
    output logic      ds_intx_o
);
    // Registered gating of each request
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_acc_o    <= 1'b0;
            mem_acc_o   <= 1'b0;
            us_fwd_o    <= 1'b0;
            us_ur_o     <= 1'b0;
            us_ur_cpl_o <= 1'b0;
            own_go_o    <= 1'b0;
            par_act_o   <= 1'b0;
            err_req_o   <= 1'b0;
            own_intx_o  <= 1'b0;
            ds_intx_o   <= 1'b0;
        end else begin
            io_acc_o    <= io_req_i & ctl.io_en;
            mem_acc_o   <= mem_req_i & ctl.mem_en;
            us_fwd_o    <= us_req_i & ctl.bme;
            us_ur_o     <= us_req_i & ~ctl.bme;
            us_ur_cpl_o <= us_req_i & us_np_i & ~ctl.bme;
            own_go_o    <= own_req_i & ctl.bme;
            par_act_o   <= par_err_i & ctl.perr_en;
            err_req_o   <= err_det_i & ctl.serr_en;
            own_intx_o  <= own_intx_i & ~ctl.intx_dis;
            ds_intx_o   <= ds_intx_i;
        end
    end
endmodule : swpc_traffic_gate
`default_nettype wire

// ==== test/swpc_rc_model.sv ====
// Purpose: Root complex model issuing configuration requests
// Assumes: Answer strobe comes one cycle after the take
// Notes:   Signals change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module swpc_rc_model (
    // Clock and answer
    input  wire logic                 clk_i,
    input  wire logic                 ack_i,
    input  wire swpc_pkg::swpc_word_t rdata_i,
    // Request
    output logic                      req_o = 1'b0,
    output logic                      wr_o = 1'b0,
    output logic [11:0]               addr_o = 12'h000,
    output logic [3:0]                be_o = 4'h0,
    output swpc_pkg::swpc_word_t      wdata_o = 32'h0
);
    import swpc_pkg::*;
    // One transfer, held until the answer is seen
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [3:0] b, input swpc_word_t d,
                        output swpc_word_t q);
        int n;
        n = 0;
        @(negedge clk_i);
        {req_o, wr_o, addr_o, be_o, wdata_o} = {1'b1, w, a, b, d};
        @(negedge clk_i);
        while (ack_i !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        // Unknown data on a missing answer fails every compare
        q = (ack_i === 1'b1) ? rdata_i : 32'hxxxx_xxxx;
        // Hold through the rising edge that samples the answer
        @(negedge clk_i);
        // Released lines show inverted values, never the last ones
        {req_o, wr_o, addr_o, be_o, wdata_o} = {1'b0, ~w, ~a, ~b, ~d};
    endtask : xfer
endmodule : swpc_rc_model
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Random register and event test of the port registers
// Assumes: Inputs change on the falling edge
// Notes:   Expectations built from the field masks
`timescale 1ns/1ps
`default_nettype none
`include "swpc_regs.svh"
module testbench;
    import swpc_pkg::*;
    localparam logic [15:0] ID_DEF = 16'h3c3c; // Arbitrary value
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            ld = 1'b0;
    swpc_half_t      idv = 16'h0;
    logic [13:0]     ev = 14'h0;
    logic [13:0]     e;
    wire logic       req, wr, ack;
    wire logic [11:0] adr;
    wire logic [3:0] be_w;
    wire swpc_word_t wdt, rdt;
    wire logic [9:0] gt;
    swpc_word_t      q, wd, m;
    swpc_half_t      cmd = 16'h0;
    logic [7:0]      fl = 8'h0;
    logic [3:0]      be;
    integer          seed = 30;
    int              fails = 0;
    int              tests_run = 0;
    // Clock and watchdog
    always #2 clk = ~clk;
    initial begin
        #20000 fails++;
        give_verdict();
    end
    swpc_rc_model swpc_rc_model_inst (.clk_i(clk), .ack_i(ack),
        .rdata_i(rdt), .req_o(req), .wr_o(wr), .addr_o(adr), .be_o(be_w),
        .wdata_o(wdt));
    swpc_port_regs #(.ID_DEFAULT(ID_DEF)) swpc_port_regs_inst (
        .CLK_SYS_I(clk), .ARST_N_I(rst_n), .CFG_REQ_I(req), .CFG_WR_I(wr),
        .CFG_ADDR_I(adr), .CFG_BE_I(be_w), .CFG_WDATA_I(wdt),
        .CFG_ACK_O(ack), .CFG_RDATA_O(rdt), .ID_LOAD_I(ld),
        .ID_LOAD_VAL_I(idv), .PRI_IO_REQ_I(ev[0]), .PRI_MEM_REQ_I(ev[1]),
        .PRI_IO_ACC_O(gt[0]), .PRI_MEM_ACC_O(gt[1]), .US_REQ_I(ev[2]),
        .US_NP_I(ev[3]), .OWN_REQ_I(ev[4]), .US_FWD_O(gt[2]),
        .US_UR_O(gt[3]), .US_UR_CPL_O(gt[4]), .OWN_REQ_GO_O(gt[5]),
        .PAR_ERR_I(ev[5]), .ERR_DET_I(ev[6]), .ERR_MSG_SENT_I(ev[7]),
        .PAR_ACT_O(gt[6]), .ERR_MSG_REQ_O(gt[7]), .CA_SENT_I(ev[8]),
        .CA_RCVD_I(ev[9]), .UR_RCVD_I(ev[10]), .POISON_I(ev[11]),
        .OWN_INTX_I(ev[12]), .DS_INTX_I(ev[13]), .OWN_INTX_O(gt[8]),
        .DS_INTX_O(gt[9]));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // Gated answers expected for one set of request pulses
    function automatic logic [9:0] gexp(input swpc_half_t c,
                                        input logic [13:0] x);
        return {x[13], x[12] & ~c[10], x[6] & c[8], x[5] & c[6],
                x[4] & c[2], x[2] & x[3] & ~c[2], x[2] & ~c[2],
                x[2] & c[2], x[1] & c[1], x[0] & c[0]};
    endfunction : gexp
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        swpc_rc_model_inst.xfer(1'b0, 12'h004, 4'hf, 32'h0, q);
        chk("sts_rst", q, 32'h00100000);
        swpc_rc_model_inst.xfer(1'b1, 12'h000, 4'hf, 32'hffffffff, q);
        swpc_rc_model_inst.xfer(1'b0, 12'h000, 4'hf, 32'h0, q);
        chk("id", q, {ID_DEF, 16'h0000});
        swpc_rc_model_inst.xfer(1'b0, 12'h0f0, 4'hf, 32'h0, q);
        chk("unmapped", q, 32'h0);
        idv = 16'($random(seed));
        ld = 1'b1;
        // Load drops as the read is raised, one cycle behind it
        fork begin
            @(negedge clk);
            ld = 1'b0;
        end join_none
        swpc_rc_model_inst.xfer(1'b0, 12'h000, 4'hf, 32'h0, q);
        chk("id_load", q, {idv, 16'h0000});
        for (int i = 0; i < 40; i++) begin
            wd = (i == 0) ? 32'hffffffff : $random(seed);
            be = (i == 0) ? 4'hf : 4'($random(seed));
            m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            swpc_rc_model_inst.xfer(1'b1, 12'h004, be, wd, q);
            chk("wr_rdata", q, 32'h0);
            cmd = (cmd & ~m[15:0]) | (wd[15:0] & m[15:0] & `SWPC_CMD_WR_MASK);
            fl = fl & ~(wd[31:24] & m[31:24] & `SWPC_STS_W1C_MASK);
            e = 14'($random(seed));
            @(negedge clk);
            ev = e;
            @(negedge clk);
            ev = 14'h0;
            chk("gates", gt, gexp(cmd, e));
            fl = fl | {e[11], e[7] & cmd[8], e[10:8], 2'b00, e[5] & cmd[6]};
            swpc_rc_model_inst.xfer(1'b0, 12'h004, 4'hf, 32'h0, q);
            chk("cmdsts", q, {fl, 8'h10, cmd});
        end
        // Reset in mid-run clears command and flags, restores the default identifier
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        swpc_rc_model_inst.xfer(1'b0, 12'h004, 4'hf, 32'h0, q);
        chk("sts_rst2", q, 32'h00100000);
        swpc_rc_model_inst.xfer(1'b0, 12'h000, 4'hf, 32'h0, q);
        chk("id_rst", q, {ID_DEF, 16'h0000});
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
